// ### gdp_config_three.sv
// How it works
// - Select bit 1 delays FRAME one clock after GNT; 0 adds no delay.
// - Parameter enable matters only at 100 Mbps, never at 10 Mbps.
// - Parameter writes need both EEPROM mode bits 1 and, at 100 Mbps, enable 0.
// - Enable 1 allows auto-load and, at 100 Mbps, blocks software parameter writes.
// - A rise of link OK at 100 Mbps with enable 1 auto-loads both PHY parameters unless a load is busy.
// - Mode-protected bits are writable only with both mode bits 1.
// - Link status reads inverted: 0 link OK, 1 link failed.
// - Speed flag reads 1 at 10 Mbps, 0 at 100 Mbps.
`default_nettype none
module gdp_config_three (
	// Clock and reset.
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// APB slave.
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [gdp_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Pins: strap and PHY status.
	input  wire logic                       frame_sel_strap,
	input  wire logic                       phy_link_ok,
	input  wire logic                       phy_speed_10,
	// PCI master timing, same clock.
	input  wire logic                       bus_req,
	input  wire logic                       gnt_n,
	input  wire logic                       xfer_last,
	output logic                            frame_n,
	// EEPROM word read handshake.
	output logic                            ee_req,
	output logic [5:0]                      ee_addr,
	input  wire logic                       ee_ack,
	input  wire logic [15:0]                ee_data,
	// Parameters toward the PHY.
	output logic [15:0]                     phy_param_one,
	output logic [15:0]                     phy_param_two,
	output logic [15:0]                     twister_param
);
	logic        strap_s1, strap_s2, link_s1, link_s2, spd_s1, spd_s2;
	logic        strap_v1, strap_v2;
	logic        strap_taken, frame_delay_select, param_autoload_enable;
	logic        eeprom_mode_hi, eeprom_mode_lo, link_fail_flag, speed_10;
	logic        link_100_prev, al_busy, al_one, al_two, al_start;
	logic [15:0] al_data;
	logic [9:0]  idx;
	logic        wr_commit;
	gdp_pkg::gdp_fr_state_t fr_state;

	// Software may touch a parameter only when this says so.
	function automatic logic param_wr_ok(input logic en, input logic spd10,
		input logic hi, input logic lo);
		param_wr_ok = hi && lo && (spd10 || !en);
	endfunction : param_wr_ok

	function automatic logic mapped(input logic [9:0] i);
		mapped = (i == gdp_pkg::IDX_EE_CMD) || (i == gdp_pkg::IDX_MEDIA) ||
			(i == gdp_pkg::IDX_CONFIG_THREE) || (i == gdp_pkg::IDX_PHY_ONE) ||
			(i == gdp_pkg::IDX_PHY_TWO) || (i == gdp_pkg::IDX_TWISTER);
	endfunction : mapped

	assign idx       = paddr[gdp_pkg::ADDR_W-1:2];
	assign wr_commit = psel && penable && pready && pwrite;

	// Pins come from outside the clock domain, so two flops each.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1 <= 1'h0;
			strap_s2 <= 1'h0;
			link_s1  <= 1'h0;
			link_s2  <= 1'h0;
			spd_s1   <= 1'h1;
			spd_s2   <= 1'h1;
		end else begin
			strap_s1 <= frame_sel_strap;
			strap_s2 <= strap_s1;
			link_s1  <= phy_link_ok;
			link_s2  <= link_s1;
			spd_s1   <= phy_speed_10;
			spd_s2   <= spd_s1;
		end
	end

	// Status flags as software reads them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_fail_flag <= 1'h1;
			speed_10       <= 1'h1;
		end else begin
			link_fail_flag <= !link_s2;
			speed_10       <= spd_s2;
		end
	end

	// The read-only select is caught once, when the strap's sync flops
	// hold the pin; an earlier catch would see their reset value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_v1           <= 1'h0;
			strap_v2           <= 1'h0;
			strap_taken        <= 1'h0;
			frame_delay_select <= 1'h0;
		end else begin
			strap_v1 <= 1'h1;
			strap_v2 <= strap_v1;
			if (strap_v2 && !strap_taken) begin
				strap_taken        <= 1'h1;
				frame_delay_select <= strap_s2;
			end
		end
	end

	// Mode bits always writable; the enable only when unlocked.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eeprom_mode_hi        <= gdp_pkg::EE_MODE_RST[1];
			eeprom_mode_lo        <= gdp_pkg::EE_MODE_RST[0];
			param_autoload_enable <= gdp_pkg::PARAM_EN_RST;
		end else if (wr_commit) begin
			if (idx == gdp_pkg::IDX_EE_CMD) begin
				eeprom_mode_hi <= pwdata[gdp_pkg::EE_MODE_HI];
				eeprom_mode_lo <= pwdata[gdp_pkg::EE_MODE_LO];
			end
			if (idx == gdp_pkg::IDX_CONFIG_THREE &&
				{eeprom_mode_hi, eeprom_mode_lo} == gdp_pkg::EE_MODE_UNLOCK) begin
				param_autoload_enable <= pwdata[gdp_pkg::CFG3_PARAM_EN];
			end
		end
	end

	// Trigger on the rise of link OK at 100 Mbps; busy loads swallow it.
	assign al_start = link_s2 && !spd_s2 && !link_100_prev &&
		param_autoload_enable && !al_busy;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_100_prev <= 1'h0;
		end else begin
			link_100_prev <= link_s2 && !spd_s2;
		end
	end

	gdp_autoload u_autoload (
		.clk       (clk),
		.rst_n     (rst_n),
		.start     (al_start),
		.busy      (al_busy),
		.ee_req    (ee_req),
		.ee_addr   (ee_addr),
		.ee_ack    (ee_ack),
		.ee_data   (ee_data),
		.load_one  (al_one),
		.load_two  (al_two),
		.load_data (al_data)
	);

	// Auto-load wins over a software write landing in the same cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phy_param_one <= gdp_pkg::PARAM_RST;
			phy_param_two <= gdp_pkg::PARAM_RST;
			twister_param <= gdp_pkg::PARAM_RST;
		end else begin
			if (al_one) begin
				phy_param_one <= al_data;
			end else if (wr_commit && idx == gdp_pkg::IDX_PHY_ONE &&
				param_wr_ok(param_autoload_enable, speed_10,
				eeprom_mode_hi, eeprom_mode_lo)) begin
				phy_param_one <= pwdata[15:0];
			end
			if (al_two) begin
				phy_param_two <= al_data;
			end else if (wr_commit && idx == gdp_pkg::IDX_PHY_TWO &&
				param_wr_ok(param_autoload_enable, speed_10,
				eeprom_mode_hi, eeprom_mode_lo)) begin
				phy_param_two <= pwdata[15:0];
			end
			if (wr_commit && idx == gdp_pkg::IDX_TWISTER &&
				param_wr_ok(param_autoload_enable, speed_10,
				eeprom_mode_hi, eeprom_mode_lo)) begin
				twister_param <= pwdata[15:0];
			end
		end
	end

	// One wait state: pready rises in the second access cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped(idx);
			prdata  <= 32'h00000000;
			if (psel && penable && !pready && !pwrite) begin
				case (idx)
					gdp_pkg::IDX_EE_CMD: begin
						prdata[gdp_pkg::EE_MODE_HI] <= eeprom_mode_hi;
						prdata[gdp_pkg::EE_MODE_LO] <= eeprom_mode_lo;
					end
					gdp_pkg::IDX_MEDIA: begin
						prdata[gdp_pkg::MEDIA_SPEED10]   <= speed_10;
						prdata[gdp_pkg::MEDIA_LINK_FAIL] <= link_fail_flag;
					end
					gdp_pkg::IDX_CONFIG_THREE: begin
						prdata[gdp_pkg::CFG3_FRAME_SEL] <= frame_delay_select;
						prdata[gdp_pkg::CFG3_PARAM_EN]  <= param_autoload_enable;
					end
					gdp_pkg::IDX_PHY_ONE: prdata[15:0] <= phy_param_one;
					gdp_pkg::IDX_PHY_TWO: prdata[15:0] <= phy_param_two;
					gdp_pkg::IDX_TWISTER: prdata[15:0] <= twister_param;
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// FRAME follows the sampled grant at once or one clock later.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fr_state <= gdp_pkg::FR_IDLE;
			frame_n  <= 1'h1;
		end else begin
			case (fr_state)
				gdp_pkg::FR_IDLE: begin
					if (bus_req && !gnt_n) begin
						if (frame_delay_select) begin
							fr_state <= gdp_pkg::FR_WAIT;
						end else begin
							fr_state <= gdp_pkg::FR_FRAME;
							frame_n  <= 1'h0;
						end
					end
				end
				gdp_pkg::FR_WAIT: begin
					fr_state <= gdp_pkg::FR_FRAME;
					frame_n  <= 1'h0;
				end
				gdp_pkg::FR_FRAME: begin
					if (xfer_last) begin
						fr_state <= gdp_pkg::FR_IDLE;
						frame_n  <= 1'h1;
					end
				end
				default: begin
					fr_state <= gdp_pkg::FR_IDLE;
					frame_n  <= 1'h1;
				end
			endcase
		end
	end

	a_frame_nodelay: assert property (@(posedge clk) disable iff (!rst_n)
		(fr_state == gdp_pkg::FR_IDLE && bus_req && !gnt_n &&
		!frame_delay_select) |=> !frame_n)
		else $error("FRAME not asserted right after grant");
	a_frame_delay: assert property (@(posedge clk) disable iff (!rst_n)
		(fr_state == gdp_pkg::FR_IDLE && bus_req && !gnt_n &&
		frame_delay_select) |=> frame_n ##1 !frame_n)
		else $error("FRAME delay of one clock not kept");
	a_param_guard: assert property (@(posedge clk) disable iff (!rst_n)
		(!al_one && !$past(al_one) && $changed(phy_param_one)) |->
		$past(param_wr_ok(param_autoload_enable, speed_10,
		eeprom_mode_hi, eeprom_mode_lo)))
		else $error("Parameter one written while locked");
	a_twister_lock: assert property (@(posedge clk) disable iff (!rst_n)
		(param_autoload_enable && !speed_10) |=> $stable(twister_param))
		else $error("Twister parameter written in auto-load mode");
	a_enable_lock: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(param_autoload_enable) |->
		$past(eeprom_mode_hi && eeprom_mode_lo))
		else $error("Enable changed while mode bits locked");
	a_link_flag: assert property (@(posedge clk) disable iff (!rst_n)
		link_s2 |=> !link_fail_flag)
		else $error("Link fail flag not inverted");
	a_speed_flag: assert property (@(posedge clk) disable iff (!rst_n)
		spd_s2 |=> speed_10)
		else $error("Speed flag does not track 10 Mbps");
	a_load_starts: assert property (@(posedge clk) disable iff (!rst_n)
		al_start |=> ee_req ##[1:60] ee_addr == gdp_pkg::EE_WORD_PHY_TWO)
		else $error("Auto-load did not start on link OK");
	a_no_load_10m: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ee_req) |-> !speed_10)
		else $error("Auto-load started at 10 Mbps");
	a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && penable && !pready) |=> pready)
		else $error("APB access not answered in one cycle");
	c_sw_write: cover property (@(posedge clk) disable iff (!rst_n)
		wr_commit && idx == gdp_pkg::IDX_PHY_ONE);
	c_delay_frame: cover property (@(posedge clk) disable iff (!rst_n)
		fr_state == gdp_pkg::FR_WAIT ##1 !frame_n);
	c_autoload: cover property (@(posedge clk) disable iff (!rst_n)
		al_start ##[1:60] al_two);
endmodule : gdp_config_three
`default_nettype wire

// ### gdp_pkg.sv
`default_nettype none
package gdp_pkg;
	// APB address width; registers sit at four times their index.
	localparam int          ADDR_W           = 12;
	localparam logic [9:0]  IDX_EE_CMD       = 10'h050;
	localparam logic [9:0]  IDX_MEDIA        = 10'h058;
	localparam logic [9:0]  IDX_CONFIG_THREE = 10'h059;
	localparam logic [9:0]  IDX_PHY_ONE      = 10'h060;
	localparam logic [9:0]  IDX_PHY_TWO      = 10'h061;
	localparam logic [9:0]  IDX_TWISTER      = 10'h062;
	// Field positions.
	localparam int          CFG3_FRAME_SEL   = 7;
	localparam int          CFG3_PARAM_EN    = 6;
	localparam int          EE_MODE_HI       = 7;
	localparam int          EE_MODE_LO       = 6;
	localparam int          MEDIA_SPEED10    = 3;
	localparam int          MEDIA_LINK_FAIL  = 2;
	// Reset values and the mode-bit unlock code.
	localparam logic        PARAM_EN_RST     = 1'h0;
	localparam logic [1:0]  EE_MODE_RST      = 2'h0;
	localparam logic [15:0] PARAM_RST        = 16'h0000;
	localparam logic [1:0]  EE_MODE_UNLOCK   = 2'h3;
	// EEPROM word addresses of the two PHY parameters.
	localparam logic [5:0]  EE_WORD_PHY_ONE  = 6'h20;
	localparam logic [5:0]  EE_WORD_PHY_TWO  = 6'h21;
	// Auto-load sequencer, Gray coded.
	typedef enum logic [1:0] {
		AL_IDLE = 2'h0,
		AL_ONE  = 2'h1,
		AL_TWO  = 2'h3,
		AL_DONE = 2'h2
	} gdp_al_state_t;
	// Bus master FRAME timing; only the steps into and out of FR_WAIT are Gray coded.
	typedef enum logic [1:0] {
		FR_IDLE  = 2'h0,
		FR_WAIT  = 2'h1,
		FR_FRAME = 2'h3
	} gdp_fr_state_t;
endpackage : gdp_pkg
`default_nettype wire

// ### gdp_autoload.sv
`default_nettype none
module gdp_autoload (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Trigger from the link monitor.
	input  wire logic        start,
	output logic             busy,
	// EEPROM word read handshake.
	output logic             ee_req,
	output logic [5:0]       ee_addr,
	input  wire logic        ee_ack,
	input  wire logic [15:0] ee_data,
	// Load strobes into the parameter registers.
	output logic             load_one,
	output logic             load_two,
	output logic [15:0]      load_data
);
	gdp_pkg::gdp_al_state_t state;

	// Two word reads in turn; a start is only seen while idle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= gdp_pkg::AL_IDLE;
			ee_req    <= 1'h0;
			ee_addr   <= 6'h00;
			load_one  <= 1'h0;
			load_two  <= 1'h0;
			load_data <= 16'h0000;
		end else begin
			load_one <= 1'h0;
			load_two <= 1'h0;
			case (state)
				gdp_pkg::AL_IDLE: begin
					if (start) begin
						state   <= gdp_pkg::AL_ONE;
						ee_req  <= 1'h1;
						ee_addr <= gdp_pkg::EE_WORD_PHY_ONE;
					end
				end
				gdp_pkg::AL_ONE: begin
					if (ee_ack) begin
						state     <= gdp_pkg::AL_TWO;
						ee_addr   <= gdp_pkg::EE_WORD_PHY_TWO;
						load_one  <= 1'h1;
						load_data <= ee_data;
					end
				end
				gdp_pkg::AL_TWO: begin
					if (ee_ack) begin
						state     <= gdp_pkg::AL_DONE;
						ee_req    <= 1'h0;
						load_two  <= 1'h1;
						load_data <= ee_data;
					end
				end
				gdp_pkg::AL_DONE: begin
					state <= gdp_pkg::AL_IDLE;
				end
				default: begin
					state  <= gdp_pkg::AL_IDLE;
					ee_req <= 1'h0;
				end
			endcase
		end
	end

	// Busy covers the settle cycle too, so a retrigger waits for it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'h0;
		end else begin
			busy <= (state != gdp_pkg::AL_IDLE) || start;
		end
	end

	a_req_held: assert property (@(posedge clk) disable iff (!rst_n)
		(ee_req && !ee_ack && state == gdp_pkg::AL_ONE) |=> ee_req)
		else $error("EEPROM request dropped before its answer");
	a_start_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		(state != gdp_pkg::AL_IDLE) |-> (busy && !start))
		else $error("Load restarted before it finished");
	c_full_load: cover property (@(posedge clk) disable iff (!rst_n)
		load_one ##[1:50] load_two);
endmodule : gdp_autoload
`default_nettype wire

// ### gdp_ee_model.sv
`default_nettype none
module gdp_ee_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Word read request from the block.
	input  wire logic        ee_req,
	input  wire logic [5:0]  ee_addr,
	// Bench controls: answer delay and data high byte.
	input  wire logic [3:0]  slow,
	input  wire logic [7:0]  tag,
	// Answer toward the block.
	output var  logic        ee_ack,
	output var  logic [15:0] ee_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_cnt;

	// Answers each word after slow cycles; between answers the data
	// lines show the inverse of the last word so stale data never matches.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ee_ack   <= 1'b0;
			wait_cnt <= 4'h0;
			ee_data  <= 16'hFFFF;
		end else begin
			ee_ack <= 1'b0;
			if (ee_ack) begin
				ee_data <= ~ee_data;
			end else if (ee_req) begin
				if (wait_cnt == slow) begin
					ee_ack   <= 1'b1;
					ee_data  <= {tag, 2'h0, ee_addr};
					wait_cnt <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule : gdp_ee_model
`default_nettype wire

// ### grant_delay_phy_param_config_bench.sv
`default_nettype none
module grant_delay_phy_param_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        strap, link, spd10, bus_req, gnt_n, xfer_last, frame_n;
	logic        ee_req, ee_ack, req_d;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [5:0]  ee_addr;
	logic [15:0] ee_data, p_one, p_two, p_tw;
	logic [3:0]  slow;
	logic [7:0]  tag;
	logic        e;
	int          bad_count, n_compared, loads, cycles;

	gdp_config_three gdp_config_three_inst (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_sel_strap(strap), .phy_link_ok(link),
		.phy_speed_10(spd10), .bus_req(bus_req), .gnt_n(gnt_n),
		.xfer_last(xfer_last), .frame_n(frame_n), .ee_req(ee_req),
		.ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data),
		.phy_param_one(p_one), .phy_param_two(p_two),
		.twister_param(p_tw));
	gdp_ee_model gdp_ee_model_inst (.clk(clk), .rst_n(rst_n),
		.ee_req(ee_req), .ee_addr(ee_addr), .slow(slow), .tag(tag),
		.ee_ack(ee_ack), .ee_data(ee_data));

	// Clock at 125 MHz.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Counts load starts and cuts a hung run short.
	always @(posedge clk) begin
		if (ee_req === 1'b1 && req_d !== 1'b1) loads++;
		req_d <= ee_req;
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] x,
			input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// One APB transfer; an idle cycle always precedes the setup phase.
	task automatic apb(input logic wr, input logic [9:0] idx,
			input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {idx, 2'h0};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		chk("apb access cycles", 32'h2, 32'(n));
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [9:0] idx, input logic [31:0] x);
		apb(1'b0, idx, 32'h0);
		chk($sformatf("reg %h", idx), x, d);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask : rd

	task automatic do_reset(input logic s);
		@(posedge clk);
		strap <= s;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : do_reset

	// Grant while requesting, then end the frame with xfer_last.
	task automatic frame_chk(input logic sel);
		@(posedge clk);
		bus_req <= 1'b1;
		gnt_n   <= 1'b0;
		@(posedge clk);
		#1 chk("frame first", {31'h0, sel}, {31'h0, frame_n});
		@(posedge clk);
		#1 chk("frame second", 32'h0, {31'h0, frame_n});
		@(posedge clk);
		gnt_n     <= 1'b1;
		bus_req   <= 1'b0;
		xfer_last <= 1'b1;
		@(posedge clk);
		xfer_last <= 1'b0;
		#1 chk("frame end", 32'h1, {31'h0, frame_n});
	endtask : frame_chk

	task automatic wait_params(input logic [7:0] t);
		int n;
		n = 0;
		while (p_two !== {t, 8'h21} && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("param one", {16'h0, t, 8'h20}, {16'h0, p_one});
		chk("param two", {16'h0, t, 8'h21}, {16'h0, p_two});
	endtask : wait_params

	// Main sequence; the strap is high for the first reset, low later.
	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; strap = 1'b1; link = 1'b0;
		spd10 = 1'b0; bus_req = 1'b0; gnt_n = 1'b1; xfer_last = 1'b0;
		slow = 4'h0; tag = 8'h11;
		do_reset(1'b1);
		frame_chk(1'b1);
		rd(gdp_pkg::IDX_CONFIG_THREE, 32'h80);
		apb(1'b0, 10'h3FF, 32'h0);
		chk("unmapped pslverr", 32'h1, {31'h0, e});
		apb(1'b1, gdp_pkg::IDX_PHY_ONE, 32'h1234);
		rd(gdp_pkg::IDX_PHY_ONE, 32'h0);
		apb(1'b1, gdp_pkg::IDX_CONFIG_THREE, 32'h40);
		rd(gdp_pkg::IDX_CONFIG_THREE, 32'h80);
		apb(1'b1, gdp_pkg::IDX_EE_CMD, 32'hC0);
		rd(gdp_pkg::IDX_EE_CMD, 32'hC0);
		apb(1'b1, gdp_pkg::IDX_PHY_ONE, 32'h1234);
		rd(gdp_pkg::IDX_PHY_ONE, 32'h1234);
		apb(1'b1, gdp_pkg::IDX_TWISTER, 32'h5678);
		rd(gdp_pkg::IDX_TWISTER, 32'h5678);
		chk("twister out", 32'h5678, {16'h0, p_tw});
		apb(1'b1, gdp_pkg::IDX_CONFIG_THREE, 32'h40);
		rd(gdp_pkg::IDX_CONFIG_THREE, 32'hC0);
		apb(1'b1, gdp_pkg::IDX_PHY_TWO, 32'h9999);
		rd(gdp_pkg::IDX_PHY_TWO, 32'h0);
		apb(1'b1, gdp_pkg::IDX_TWISTER, 32'h0001);
		rd(gdp_pkg::IDX_TWISTER, 32'h5678);
		chk("twister held", 32'h5678, {16'h0, p_tw});
		@(posedge clk);
		spd10 <= 1'b1;
		repeat (5) @(posedge clk);
		apb(1'b1, gdp_pkg::IDX_PHY_TWO, 32'h9999);
		rd(gdp_pkg::IDX_PHY_TWO, 32'h9999);
		rd(gdp_pkg::IDX_MEDIA, 32'h0C);
		@(posedge clk);
		link <= 1'b1;
		repeat (30) @(posedge clk);
		chk("loads at 10M", 32'h0, 32'(loads));
		rd(gdp_pkg::IDX_MEDIA, 32'h08);
		@(posedge clk);
		link  <= 1'b0;
		spd10 <= 1'b0;
		repeat (5) @(posedge clk);
		rd(gdp_pkg::IDX_MEDIA, 32'h04);
		@(posedge clk);
		tag  <= 8'h3C;
		link <= 1'b1;
		wait_params(8'h3C);
		repeat (40) @(posedge clk);
		chk("loads first", 32'h1, 32'(loads));
		rd(gdp_pkg::IDX_MEDIA, 32'h00);
		// A slow second load with a link bounce while it is busy.
		@(posedge clk);
		link <= 1'b0;
		slow <= 4'hC;
		tag  <= 8'hC3;
		repeat (5) @(posedge clk);
		link <= 1'b1;
		repeat (12) @(posedge clk);
		link <= 1'b0;
		repeat (4) @(posedge clk);
		link <= 1'b1;
		wait_params(8'hC3);
		repeat (60) @(posedge clk);
		chk("loads second", 32'h2, 32'(loads));
		do_reset(1'b0);
		rd(gdp_pkg::IDX_CONFIG_THREE, 32'h00);
		frame_chk(1'b0);
		test_done();
	end
endmodule : grant_delay_phy_param_config_bench
`default_nettype wire
